/* File: hdl/counter_terminal_count_control.sv */
// one 16-bit counter: terminal count, reload, output forms, retrigger, behind an ahb-lite slave
// assumes count source and gate arrive asynchronously from pins; single clock hclk
// Contract
// - output control field picks high-z, low, tc pulse or toggled output
// - tc entered after 0001 down, 9999 bcd up, ffff binary up
// - tc lasts one count period regardless of gating or arming
// - every tc reloads counter from the chosen load or hold register
// - toggled output flips on the trailing edge of each tc
// - minimum delay one-shot toggles on source pulse after trigger edge
// - commit before tc: retrigger or load cannot delay coming tc
// - tc-driving count may be source edge, load command or step
// - load during the cycle before tc enters tc at once
// - load or step during tc ends tc at once
// - during tc the next source edge counts unless it lands in a command write cycle
// - value after tc differs by one from the reloaded value
// - reload equal to pre-terminal value keeps tc and toggles each count
// - direction and code bits work independently of everything else
// - repeat bit set repeats; clear disarms after one cycle of tcs
// - reload source bit picks load only, or load/hold by gate or alternation
// - alternating reloads give toggled high from load, low from hold
// - with gating, retrigger bit makes active gate edges retrigger
// - retrigger copies counter to hold; next qualified edge loads load register
// - level gating retriggers on active-going edge; edge gating start edge retriggers
// - without gating, retrigger bit with reload source bit set makes gate choose reload source
// - gate low picks load register, gate high picks hold register
// - reset and master reset preset the mode register
// - gating code zero counts unconditionally while armed
`timescale 1ns/1ps
`include "counter_tc_defines.svh"

module counter_terminal_count_control (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic count_source,
    input wire logic gate_in,
    output logic out_level,
    output logic out_en
);

    counter_tc_pkg::mode_t mode;
    counter_tc_pkg::ahb_req_t req;
    counter_tc_pkg::bus_state_t bus_state;
    logic [15:0] load_reg;
    logic [15:0] hold_reg;
    logic [15:0] cnt;
    logic terminal_count;
    logic toggled_terminal_output;
    logic armed;
    logic triggered;
    logic retrig_pend;
    logic tc_seen;
    logic use_hold;
    logic [7:0] wr_addr;

    // bus: writes land at the end of the data phase, reads are registered at the address phase
    logic take;
    logic wr_now;
    logic wr_cmd;
    logic [15:0] wdat;
    assign take = hsel && hready && htrans[1];
    assign wr_now = bus_state == counter_tc_pkg::ST_DATA;
    assign wr_cmd = wr_now && wr_addr == `OFS_CMD;
    assign wdat = hwdata[15:0];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_state <= counter_tc_pkg::ST_IDLE;
            wr_addr <= 8'h00;
        end else if (take && hwrite) begin
            bus_state <= counter_tc_pkg::ST_DATA;
            wr_addr <= haddr[7:0];
        end else begin
            bus_state <= counter_tc_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            req <= '0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (hready) begin
                req <= '{sel: hsel, addr: haddr, trans: htrans, write: hwrite, size: hsize};
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (take && !hwrite) begin
            case (haddr[7:0])
                `OFS_MODE: hrdata <= {16'h0000, mode};
                `OFS_LOAD: hrdata <= {16'h0000, load_reg};
                `OFS_HOLD: hrdata <= {16'h0000, hold_reg};
                `OFS_COUNT: hrdata <= {16'h0000, cnt};
                `OFS_STATUS: hrdata <= {26'h0000000, use_hold, tc_seen, retrig_pend,
                                        toggled_terminal_output, terminal_count, armed};
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    logic cmd_arm, cmd_load, cmd_disarm, cmd_save, cmd_step, cmd_set, cmd_clr, cmd_mreset;
    assign cmd_arm = wr_cmd && (wdat[`CMD_ARM] || wdat[`CMD_LOAD_ARM]);
    assign cmd_load = wr_cmd && (wdat[`CMD_LOAD] || wdat[`CMD_LOAD_ARM]);
    assign cmd_disarm = wr_cmd && wdat[`CMD_DISARM];
    assign cmd_save = wr_cmd && wdat[`CMD_SAVE];
    assign cmd_step = wr_cmd && wdat[`CMD_STEP];
    assign cmd_set = wr_cmd && wdat[`CMD_SET_OUT];
    assign cmd_clr = wr_cmd && wdat[`CMD_CLEAR_OUT];
    assign cmd_mreset = wr_cmd && wdat[`CMD_MASTER_RESET];

    // pin synchronisers: a level is taken once stages two and three agree
    logic [`SYNC_STAGES-1:0] src_sync;
    logic [`SYNC_STAGES-1:0] gate_sync;
    logic src_lvl, gate_lvl;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            src_sync <= '0;
            gate_sync <= '0;
            src_lvl <= 1'b0;
            gate_lvl <= 1'b0;
        end else begin
            src_sync <= {src_sync[1:0], count_source};
            gate_sync <= {gate_sync[1:0], gate_in};
            if (src_sync[1] == src_sync[2]) begin
                src_lvl <= src_sync[2];
            end
            if (gate_sync[1] == gate_sync[2]) begin
                gate_lvl <= gate_sync[2];
            end
        end
    end

    logic src_edge, gate_rise, gate_fall, gate_act_edge, gated_on;
    assign src_edge = mode.src_fall ? (src_lvl && !src_sync[2] && src_sync[1] == src_sync[2])
                                    : (!src_lvl && src_sync[2] && src_sync[1] == src_sync[2]);
    assign gate_rise = !gate_lvl && gate_sync[2] && gate_sync[1] == gate_sync[2];
    assign gate_fall = gate_lvl && !gate_sync[2] && gate_sync[1] == gate_sync[2];
    assign gate_act_edge = (mode.gating == `GATE_LEVEL_LO || mode.gating == `GATE_EDGE_FALL)
                           ? gate_fall : gate_rise;
    always_comb begin
        case (mode.gating)
            `GATE_NONE: gated_on = 1'b1;
            `GATE_LEVEL_LO: gated_on = !gate_lvl;
            `GATE_EDGE_RISE, `GATE_EDGE_FALL: gated_on = triggered;
            default: gated_on = gate_lvl;
        endcase
    end

    // one bcd or binary step in the chosen direction
    function automatic logic [15:0] step_val(input logic [15:0] v, input logic up, input logic bcd);
        logic [15:0] r;
        logic carry;
        r = v;
        carry = 1'b1;
        if (!bcd) begin
            r = up ? 16'(v + 16'h0001) : 16'(v - 16'h0001);
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (carry) begin
                    if (up) begin
                        carry = v[i*4 +: 4] == 4'h9;
                        r[i*4 +: 4] = carry ? 4'h0 : 4'(v[i*4 +: 4] + 4'h1);
                    end else begin
                        carry = v[i*4 +: 4] == 4'h0;
                        r[i*4 +: 4] = carry ? 4'h9 : 4'(v[i*4 +: 4] - 4'h1);
                    end
                end
            end
        end
        return r;
    endfunction

    logic [15:0] pre_val, reload_val, next_cnt;
    logic pre_tc, gate_picks, retrig_ev, src_ev, qual_ev, count_ev, retrig_reload, plain_load;
    logic tc_entry, last_tc;
    assign pre_val = !mode.direction_bit ? `PRE_DOWN
                   : mode.code_select_bit ? `PRE_UP_BCD : `PRE_UP_BIN;
    assign pre_tc = cnt == pre_val;
    assign next_cnt = step_val(cnt, mode.direction_bit, mode.code_select_bit);
    assign gate_picks = mode.gating == `GATE_NONE && mode.retrigger_bit;
    always_comb begin
        if (!mode.reload_source_bit) begin
            reload_val = load_reg;
        end else if (gate_picks) begin
            reload_val = gate_lvl ? hold_reg : load_reg;
        end else begin
            reload_val = (use_hold != pre_tc) ? hold_reg : load_reg;
        end
    end
    // command writes win the cycle; a source edge in that same cycle is dropped
    assign src_ev = src_edge && !wr_cmd;
    assign qual_ev = src_ev && armed && gated_on;
    assign retrig_ev = gate_act_edge && armed && mode.gating != `GATE_NONE && mode.retrigger_bit;
    assign retrig_reload = qual_ev && retrig_pend && !pre_tc && !terminal_count;
    assign plain_load = cmd_load && !pre_tc && !terminal_count;
    assign count_ev = ((src_ev && (qual_ev || terminal_count)) || cmd_step
                      || (cmd_load && (pre_tc || terminal_count))) && !retrig_reload;
    assign tc_entry = count_ev && pre_tc;
    assign last_tc = !mode.reload_source_bit || gate_picks || tc_seen;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode <= `MODE_RESET;
            load_reg <= 16'h0000;
        end else if (cmd_mreset) begin
            mode <= `MODE_RESET;
            load_reg <= 16'h0000;
        end else if (wr_now && wr_addr == `OFS_MODE) begin
            mode <= wdat;
        end else if (wr_now && wr_addr == `OFS_LOAD) begin
            load_reg <= wdat;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hold_reg <= 16'h0000;
        end else if (cmd_mreset) begin
            hold_reg <= 16'h0000;
        end else if (retrig_ev || cmd_save) begin
            hold_reg <= cnt;
        end else if (wr_now && wr_addr == `OFS_HOLD) begin
            hold_reg <= wdat;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt <= 16'h0000;
            terminal_count <= 1'b0;
        end else if (cmd_mreset) begin
            cnt <= 16'h0000;
            terminal_count <= 1'b0;
        end else if (retrig_reload) begin
            cnt <= load_reg;
        end else if (plain_load) begin
            cnt <= reload_val;
        end else if (count_ev) begin
            cnt <= pre_tc ? reload_val : next_cnt;
            terminal_count <= pre_tc;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            toggled_terminal_output <= 1'b0;
        end else if (cmd_set) begin
            toggled_terminal_output <= 1'b1;
        end else if (cmd_clr || cmd_mreset) begin
            toggled_terminal_output <= 1'b0;
        end else if (count_ev && terminal_count) begin
            toggled_terminal_output <= !toggled_terminal_output;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            armed <= 1'b0;
            tc_seen <= 1'b0;
            use_hold <= 1'b0;
        end else if (cmd_mreset || cmd_disarm) begin
            armed <= 1'b0;
            tc_seen <= 1'b0;
        end else if (cmd_arm) begin
            armed <= 1'b1;
        end else if (tc_entry) begin
            tc_seen <= !last_tc && !tc_seen;
            use_hold <= mode.reload_source_bit && !gate_picks && !use_hold;
            if (!mode.repeat_bit && last_tc) begin
                armed <= 1'b0;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            triggered <= 1'b0;
            retrig_pend <= 1'b0;
        end else if (cmd_mreset || !armed) begin
            triggered <= 1'b0;
            retrig_pend <= 1'b0;
        end else begin
            if (gate_act_edge && mode.gating[2:1] == 2'b11 && (mode.repeat_bit || !triggered)) begin
                triggered <= 1'b1;
            end else if (tc_entry && !mode.repeat_bit && last_tc) begin
                triggered <= 1'b0;
            end
            if (retrig_ev) begin
                retrig_pend <= 1'b1;
            end else if (qual_ev) begin
                retrig_pend <= 1'b0;
            end
        end
    end

    // output pin: enable high while driving
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_level <= 1'b0;
            out_en <= 1'b1;
        end else begin
            case (mode.output_control_field)
                `OUT_LOW: begin
                    out_level <= 1'b0;
                    out_en <= 1'b1;
                end
                `OUT_TC_HIGH: begin
                    out_level <= terminal_count;
                    out_en <= 1'b1;
                end
                `OUT_TC_LOW: begin
                    out_level <= !terminal_count;
                    out_en <= 1'b1;
                end
                `OUT_TOGGLE: begin
                    out_level <= toggled_terminal_output;
                    out_en <= 1'b1;
                end
                default: begin
                    out_level <= 1'b0;
                    out_en <= 1'b0;
                end
            endcase
        end
    end

    property p_tc_entry;
        @(posedge hclk) disable iff (!hresetn)
        (count_ev && pre_tc && !cmd_mreset) |=> terminal_count;
    endproperty
    a_tc_entry: assert property (p_tc_entry) else $error("tc not entered after pre-terminal count");

    property p_tc_leave;
        @(posedge hclk) disable iff (!hresetn)
        (terminal_count && count_ev && !pre_tc && !cmd_mreset) |=> !terminal_count;
    endproperty
    a_tc_leave: assert property (p_tc_leave) else $error("tc held past its count");

    property p_reload;
        @(posedge hclk) disable iff (!hresetn)
        (tc_entry && !cmd_mreset) |=> cnt == $past(reload_val);
    endproperty
    a_reload: assert property (p_reload) else $error("counter not reloaded at tc");

    property p_toggle;
        @(posedge hclk) disable iff (!hresetn)
        (terminal_count && count_ev && !wr_cmd) |=> toggled_terminal_output != $past(toggled_terminal_output);
    endproperty
    a_toggle: assert property (p_toggle) else $error("toggled output missed trailing tc edge");

    property p_tc_counts;
        @(posedge hclk) disable iff (!hresetn)
        (terminal_count && src_ev && !armed) |=> !terminal_count || cnt == $past(reload_val);
    endproperty
    a_tc_counts: assert property (p_tc_counts) else $error("disarmed counter ignored edge during tc");

    property p_once;
        @(posedge hclk) disable iff (!hresetn)
        (tc_entry && !mode.repeat_bit && last_tc && !wr_cmd) |=> !armed;
    endproperty
    a_once: assert property (p_once) else $error("single cycle counter stayed armed");

    property p_retrig_hold;
        @(posedge hclk) disable iff (!hresetn)
        (retrig_ev && !cmd_mreset) |=> hold_reg == $past(cnt) && retrig_pend;
    endproperty
    a_retrig_hold: assert property (p_retrig_hold) else $error("retrigger did not save counter");

    property p_gate_source;
        @(posedge hclk) disable iff (!hresetn)
        (tc_entry && mode.reload_source_bit && gate_picks && !cmd_mreset)
            |=> cnt == $past(gate_lvl ? hold_reg : load_reg);
    endproperty
    a_gate_source: assert property (p_gate_source) else $error("gate chose wrong reload register");

    property p_out_low;
        @(posedge hclk) disable iff (!hresetn)
        (mode.output_control_field == `OUT_LOW) [*2] |-> out_en && !out_level;
    endproperty
    a_out_low: assert property (p_out_low) else $error("output not driven low");

    c_tc: cover property (@(posedge hclk) disable iff (!hresetn) tc_entry ##1 terminal_count);
    c_retrig: cover property (@(posedge hclk) disable iff (!hresetn) retrig_ev ##[1:50] retrig_reload);
    c_stay: cover property (@(posedge hclk) disable iff (!hresetn) terminal_count && tc_entry);

endmodule // counter_terminal_count_control

/* File: inc/counter_tc_defines.svh */
// offsets, field positions, reset values and timing counts for the terminal count counter
// assumes a 32-bit ahb-lite bus, word aligned registers
`ifndef COUNTER_TC_DEFINES_SVH
`define COUNTER_TC_DEFINES_SVH

`define OFS_MODE 8'h00
`define OFS_LOAD 8'h04
`define OFS_HOLD 8'h08
`define OFS_COUNT 8'h0c
`define OFS_CMD 8'h10
`define OFS_STATUS 8'h14

`define MODE_RESET 16'h0b00

`define OUT_LOW 3'h0
`define OUT_TC_HIGH 3'h1
`define OUT_TC_LOW 3'h2
`define OUT_HIZ 3'h4
`define OUT_TOGGLE 3'h5

`define GATE_NONE 3'h0
`define GATE_LEVEL_HI 3'h4
`define GATE_LEVEL_LO 3'h5
`define GATE_EDGE_RISE 3'h6
`define GATE_EDGE_FALL 3'h7

`define CMD_ARM 0
`define CMD_LOAD 1
`define CMD_LOAD_ARM 2
`define CMD_DISARM 3
`define CMD_SAVE 4
`define CMD_STEP 5
`define CMD_SET_OUT 6
`define CMD_CLEAR_OUT 7
`define CMD_MASTER_RESET 8

`define PRE_DOWN 16'h0001
`define PRE_UP_BCD 16'h9999
`define PRE_UP_BIN 16'hffff

`define SYNC_STAGES 3

`endif

/* File: inc/counter_tc_pkg.sv */
// types used by the terminal count counter; the bench uses only the defines header
// assumes the defines header holds all numbers
package counter_tc_pkg;

    typedef struct packed {
        logic [2:0] gating;
        logic src_fall;
        logic [3:0] src_sel;
        logic retrigger_bit;
        logic reload_source_bit;
        logic repeat_bit;
        logic code_select_bit;
        logic direction_bit;
        logic [2:0] output_control_field;
    } mode_t;

    typedef struct packed {
        logic sel;
        logic [31:0] addr;
        logic [1:0] trans;
        logic write;
        logic [2:0] size;
    } ahb_req_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_DATA = 2'b10
    } bus_state_t;

endpackage

/* File: verification/pin_source.sv */
// pin-side model: count source pulses and gate level
// assumes hclk from the bench; calls come right after a rising edge
`timescale 1ns/1ps
module pin_source (
    input wire logic hclk,
    output logic count_source,
    output logic gate_in
);
    initial begin
        count_source = 1'b0;
        gate_in = 1'b0;
    end
    // widths stay above the 3-flop sync window, else edges are lost
    task automatic pulse(input int w);
        repeat (w) @(posedge hclk);
        count_source <= 1'b1;
        repeat (w) @(posedge hclk);
        count_source <= 1'b0;
        repeat (w + 2) @(posedge hclk);
    endtask
    task automatic gate(input logic v);
        gate_in <= v;
        repeat (8) @(posedge hclk);
    endtask
endmodule // pin_source

/* File: verification/counter_terminal_count_control_test.sv */
// self-checking bench for the terminal count counter
// assumes a zero-wait ahb-lite slave and the pin_source model
`timescale 1ns/1ps
`include "counter_tc_defines.svh"
module counter_terminal_count_control_test;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic count_source, gate_in, out_level, out_en, tg;
    logic [31:0] haddr, hwdata, hrdata, r, v;
    logic [1:0] htrans;
    logic [2:0] hsize;
    int fails = 0;
    int check_count = 0;
    int i;
    logic [31:0] seed = 32'h2d429e22;
    logic [15:0] st_v [3] = '{16'h0002, 16'h9998, 16'hfffe};
    logic [15:0] pre_v [3] = '{16'h0001, 16'h9999, 16'hffff};
    logic [4:0] ctl [3] = '{5'h04, 5'h07, 5'h01};
    logic [2:0] oc [3] = '{`OUT_TC_HIGH, `OUT_TC_LOW, `OUT_TOGGLE};
    counter_terminal_count_control dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .count_source(count_source),
        .gate_in(gate_in), .out_level(out_level), .out_en(out_en));
    pin_source pins (.hclk(hclk), .count_source(count_source), .gate_in(gate_in));
    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [31:0] md(input logic [2:0] o, input logic [4:0] c, input logic [2:0] g);
        return {16'h0, g, 5'h0, c, o};
    endfunction
    function automatic logic eo(input logic [2:0] o, input logic tc, input logic t);
        return (o == `OUT_TC_HIGH) ? tc : ((o == `OUT_TC_LOW) ? ~tc : t);
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wt();
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && n < 50) begin
            @(posedge hclk);
            n++;
        end
        if (n == 50) fails++;
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        hsize <= 3'h2;
        wt();
        htrans <= 2'b00;
        hsize <= 3'h0;
        hsel <= 1'b0;
        hwdata <= d;
        wt();
        r = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic cmd(input int b);
        bus(1'b1, `OFS_CMD, 32'h1 << b);
    endtask
    task automatic rc(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
        bus(1'b0, a, 32'h0);
        chk(r & {16'h0, m}, {16'h0, e});
    endtask
    // pin is sampled on the falling edge so the register update has landed
    task automatic po(input logic en, input logic lv);
        repeat (2) @(posedge hclk);
        @(negedge hclk);
        chk({30'h0, out_en, out_level & out_en}, {30'h0, en, lv});
        @(posedge hclk);
    endtask
    task automatic pl();
        pins.pulse(3 + int'(rnd() & 32'h3));
    endtask
    // master reset first keeps every mode write on a disarmed counter
    task automatic setup(input logic [31:0] m, input logic [15:0] ld, input logic [15:0] hd);
        cmd(`CMD_MASTER_RESET);
        wr(`OFS_MODE, m);
        wr(`OFS_LOAD, {16'h0, ld});
        wr(`OFS_HOLD, {16'h0, hd});
        cmd(`CMD_LOAD_ARM);
    endtask
    task automatic final_report();
        if (fails == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge hclk);
        fails++;
        final_report();
    end
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        po(1'b1, 1'b0);
        rc(`OFS_MODE, 16'hffff, `MODE_RESET);
        rc(8'h20, 16'hffff, 16'h0);
        for (i = 0; i < 4; i++) begin
            v = rnd();
            wr(`OFS_LOAD, v);
            wr(`OFS_HOLD, ~v);
            wr(`OFS_COUNT, v);
            rc(`OFS_LOAD, 16'hffff, v[15:0]);
            rc(`OFS_HOLD, 16'hffff, ~v[15:0]);
            rc(`OFS_COUNT, 16'hffff, 16'h0);
        end
        wr(`OFS_MODE, md(`OUT_HIZ, 5'h0, `GATE_NONE));
        po(1'b0, 1'b0);
        for (i = 0; i < 3; i++) begin
            setup(md(oc[i], ctl[i], `GATE_NONE), st_v[i], 16'h0);
            rc(`OFS_MODE, 16'hffff, 16'(md(oc[i], ctl[i], `GATE_NONE)));
            tg = (i == 2);
            if (tg) cmd(`CMD_SET_OUT);
            pl();
            rc(`OFS_COUNT, 16'hffff, pre_v[i]);
            po(1'b1, eo(oc[i], 1'b0, tg));
            pl();
            rc(`OFS_COUNT, 16'hffff, st_v[i]);
            rc(`OFS_STATUS, 16'h2, 16'h2);
            po(1'b1, eo(oc[i], 1'b1, tg));
            if (i == 0) cmd(`CMD_DISARM);
            pl();
            rc(`OFS_COUNT, 16'hffff, pre_v[i]);
            rc(`OFS_STATUS, 16'h3, {15'h0, i == 1});
            po(1'b1, eo(oc[i], 1'b0, 1'b0));
        end
        setup(md(`OUT_TC_HIGH, 5'h04, `GATE_NONE), 16'h3, 16'h0);
        pl();
        pl();
        cmd(`CMD_LOAD);
        rc(`OFS_STATUS, 16'h2, 16'h2);
        rc(`OFS_COUNT, 16'hffff, 16'h3);
        cmd(`CMD_LOAD);
        rc(`OFS_STATUS, 16'h2, 16'h0);
        setup(md(`OUT_TOGGLE, 5'h04, `GATE_NONE), 16'h1, 16'h0);
        cmd(`CMD_SET_OUT);
        pl();
        po(1'b1, 1'b1);
        pl();
        po(1'b1, 1'b0);
        cmd(`CMD_STEP);
        po(1'b1, 1'b1);
        rc(`OFS_STATUS, 16'h2, 16'h2);
        pins.gate(1'b0);
        setup(md(`OUT_TC_HIGH, 5'h14, `GATE_LEVEL_HI), 16'ha, 16'h0);
        pins.gate(1'b1);
        pl();
        rc(`OFS_COUNT, 16'hffff, 16'ha);
        pl();
        pl();
        pins.gate(1'b0);
        pl();
        rc(`OFS_COUNT, 16'hffff, 16'h8);
        pins.gate(1'b1);
        rc(`OFS_HOLD, 16'hffff, 16'h8);
        pl();
        rc(`OFS_COUNT, 16'hffff, 16'ha);
        // gate low first, else the load command itself picks the hold register
        pins.gate(1'b0);
        setup(md(`OUT_TC_HIGH, 5'h1c, `GATE_NONE), 16'h2, 16'h5);
        rc(`OFS_COUNT, 16'hffff, 16'h2);
        pl();
        pins.gate(1'b1);
        pl();
        rc(`OFS_COUNT, 16'hffff, 16'h5);
        pins.gate(1'b0);
        repeat (5) pl();
        rc(`OFS_COUNT, 16'hffff, 16'h2);
        setup(md(`OUT_TOGGLE, 5'h0c, `GATE_NONE), 16'h2, 16'h3);
        cmd(`CMD_SET_OUT);
        pl();
        pl();
        rc(`OFS_COUNT, 16'hffff, 16'h3);
        pl();
        po(1'b1, 1'b0);
        setup(md(`OUT_TC_HIGH, 5'h00, `GATE_EDGE_RISE), 16'h3, 16'h0);
        pl();
        rc(`OFS_COUNT, 16'hffff, 16'h3);
        pins.gate(1'b1);
        pl();
        rc(`OFS_COUNT, 16'hffff, 16'h2);
        final_report();
    end
endmodule // counter_terminal_count_control_test
